// file: hw/ptm_cfg_if.sv
// Interface carrying decoded control fields from the register file to the core.
// Assumes both ends run on the same clock.
interface ptm_cfg_if #(parameter int W = 16);
  logic runEn;
  logic pauseEn;
  logic [2:0] clkSel;
  logic [1:0] mode;
  logic [1:0] pinFunc;
  logic initLevel;
  logic polarity;
  logic clearSel;
  logic [W-1:0] period;
  logic [W-1:0] duty;
  logic [W-1:0] count;
  logic outLevel;
  modport regs (output runEn, pauseEn, clkSel, mode, pinFunc, initLevel, polarity,
    clearSel, period, duty, input count, outLevel);
  modport core (input runEn, pauseEn, clkSel, mode, pinFunc, initLevel, polarity,
    clearSel, period, duty, output count, outLevel);
endinterface

// file: hw/ptm_counter.sv
// Counter core of the periodic timer: clock select, counter, two comparators, pin.
// Assumes external pins are already synchronised by the caller.
module ptm_counter #(
  parameter int W = 16
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic extPinSync,
  input wire logic subTick,
  input wire logic hTick,
  ptm_cfg_if.core cfg
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic [5:0] pre;
    logic [5:0] hPre;
    logic extPrev;
    logic runPrev;
    logic outLvl;
    logic pulseDone;
  } ptm_core_t;
  ptm_core_t st_reg;
  ptm_core_t st_next;
  logic tick;
  logic dutyHit;
  logic perHit;
  logic ovf;
  logic clr;

  // ===========================================================================
  // Clock source selection as a count enable
  always_comb
  begin
    unique case (cfg.clkSel)
      3'b000: tick = (st_reg.pre[1:0] == 2'(ptm_pkg::SYS_DIV - 1));
      3'b001: tick = 1'b1;
      3'b010: tick = hTick && (st_reg.hPre[3:0] == 4'(ptm_pkg::HDIV_SLOW - 1));
      3'b011: tick = hTick && (st_reg.hPre == 6'(ptm_pkg::HDIV_SLOWER - 1));
      3'b100, 3'b101: tick = subTick;
      3'b110: tick = extPinSync && !st_reg.extPrev;
      3'b111: tick = !extPinSync && st_reg.extPrev;
    endcase
  end

  // Both comparators see every counter bit
  assign dutyHit = (st_reg.cnt == cfg.duty);
  // A zero period leaves clearing to overflow, else the count would stick at zero
  assign perHit = (st_reg.cnt == cfg.period) && (cfg.period != '0);
  assign ovf = (cfg.period == '0) && (&st_reg.cnt);
  // PWM and capture always clear on period; otherwise the select bit decides
  assign clr = (cfg.clearSel && cfg.mode != 2'b10 && cfg.mode != 2'b01) ? dutyHit :
    (perHit || ovf);

  // ===========================================================================
  // Next state
  always_comb
  begin
    st_next = st_reg;
    st_next.pre = st_reg.pre + 6'd1;
    if (hTick)
      st_next.hPre = st_reg.hPre + 6'd1;
    st_next.extPrev = extPinSync;
    st_next.runPrev = cfg.runEn;
    if (cfg.runEn && !st_reg.runPrev)
    begin
      st_next.cnt = '0;
      st_next.pulseDone = 1'b0;
      st_next.outLvl = cfg.initLevel;
    end
    else if (cfg.runEn && !cfg.pauseEn && tick)
    begin
      st_next.cnt = clr ? '0 : st_reg.cnt + 1'b1;
      if (cfg.mode == 2'b00 && dutyHit)
      begin
        unique case (cfg.pinFunc)
          2'b00: st_next.outLvl = st_reg.outLvl;
          2'b01: st_next.outLvl = 1'b0;
          2'b10: st_next.outLvl = 1'b1;
          2'b11: st_next.outLvl = !st_reg.outLvl;
        endcase
      end
      else if (cfg.mode == 2'b10)
      begin
        unique case (cfg.pinFunc)
          2'b00: st_next.outLvl = !cfg.initLevel;
          2'b01: st_next.outLvl = cfg.initLevel;
          2'b10: st_next.outLvl = (clr || (st_reg.cnt + 1'b1) < cfg.duty) ?
            (cfg.duty != '0) == cfg.initLevel : st_reg.outLvl ^ dutyHit;
          2'b11:
          begin
            if (dutyHit && !st_reg.pulseDone)
            begin
              st_next.outLvl = !cfg.initLevel;
              st_next.pulseDone = 1'b1;
            end
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign cfg.count = st_reg.cnt;
  assign cfg.outLevel = st_reg.outLvl;

  // ===========================================================================
  // Checks
  runrise_clear_a: assert property (@(posedge clock) disable iff (!rstn)
    $rose(cfg.runEn) |=> st_reg.cnt == '0) else $error("count not cleared on run");
  pause_hold_a: assert property (@(posedge clock) disable iff (!rstn)
    cfg.pauseEn && $past(cfg.pauseEn) && cfg.runEn && $past(cfg.runEn) |->
    $stable(st_reg.cnt)) else $error("count moved while paused");
  off_hold_a: assert property (@(posedge clock) disable iff (!rstn)
    !cfg.runEn && !$past(cfg.runEn) |-> $stable(st_reg.cnt))
    else $error("count moved while off");
  init_level_a: assert property (@(posedge clock) disable iff (!rstn)
    $rose(cfg.runEn) |=> st_reg.outLvl == $past(cfg.initLevel))
    else $error("pin not reset on run");
  match_clear_a: assert property (@(posedge clock) disable iff (!rstn)
    cfg.runEn && st_reg.runPrev && !cfg.pauseEn && tick && clr |=> st_reg.cnt == '0)
    else $error("count not cleared on match");
  sys_count_a: assert property (@(posedge clock) disable iff (!rstn)
    cfg.runEn && st_reg.runPrev && !cfg.pauseEn && cfg.clkSel == 3'b001 && !clr |=>
    st_reg.cnt == $past(st_reg.cnt) + 1'b1) else $error("count did not advance");
  toggle_a: assert property (@(posedge clock) disable iff (!rstn)
    cfg.runEn && st_reg.runPrev && !cfg.pauseEn && tick && dutyHit && cfg.mode == 2'b00
    && cfg.pinFunc == 2'b11 |=> st_reg.outLvl != $past(st_reg.outLvl))
    else $error("pin did not toggle");
  clear_cover_c: cover property (@(posedge clock) disable iff (!rstn) tick && clr);
  pause_cover_c: cover property (@(posedge clock) disable iff (!rstn) $fell(cfg.pauseEn));
  ext_cover_c: cover property (@(posedge clock) disable iff (!rstn)
    cfg.clkSel == 3'b110 && tick);
endmodule

// file: hw/ptm_pkg.sv
// Package of the periodic timer: register map, field positions, reset values, modes.
// Assumes an AHB-Lite slave with word-aligned 8-bit registers in the low byte lane.
package ptm_pkg;
  // ===========================================================================
  // Register byte offsets
  localparam logic [7:0] CTRL0_OFS = 8'h00;
  localparam logic [7:0] CTRL1_OFS = 8'h04;
  localparam logic [7:0] CTRL2_OFS = 8'h08;
  localparam logic [7:0] CNTL_OFS = 8'h0C;
  localparam logic [7:0] CNTH_OFS = 8'h10;
  localparam logic [7:0] DUTYL_OFS = 8'h14;
  localparam logic [7:0] DUTYH_OFS = 8'h18;
  localparam logic [7:0] CAPL_OFS = 8'h1C;
  localparam logic [7:0] CAPH_OFS = 8'h20;
  localparam logic [7:0] PERL_OFS = 8'h24;
  localparam logic [7:0] PERH_OFS = 8'h28;
  // ===========================================================================
  // Field positions in control zero and control one
  localparam int PAUSE_BIT = 7;
  localparam int CKSEL_LSB = 4;
  localparam int RUN_BIT = 3;
  localparam int MODE_LSB = 6;
  localparam int PINF_LSB = 4;
  localparam int OINIT_BIT = 3;
  localparam int POL_BIT = 2;
  localparam int CAPSRC_BIT = 1;
  localparam int CCLR_BIT = 0;
  localparam logic [7:0] CTRL0_MASK = 8'hF8;
  localparam logic [7:0] CTRL2_MASK = 8'h07;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // ===========================================================================
  // Clock dividers
  localparam int SYS_DIV = 4;
  localparam int HDIV_SLOW = 16;
  localparam int HDIV_SLOWER = 64;
  typedef enum logic [1:0] {MODE_CMP, MODE_CAP, MODE_PWM, MODE_TMR} ptm_mode_t;
endpackage

// file: hw/ptm_top.sv
// Periodic timer top: AHB-Lite register file with buffered byte pairs, pin logic.
// Assumes one AHB-Lite master, word transfers, and asynchronous external pins.
module ptm_top #(
  parameter int INSTANCE = 0
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic extClockPin,
  input wire logic captureInputPin,
  input wire logic subClockTick,
  input wire logic highClockTick,
  output logic timerOutputPin,
  output logic timerOutputInvertedPin,
  output logic captureEvent
);
  localparam int W = (INSTANCE < 2) ? 16 : 10;
  localparam bit HAS_CAP = (INSTANCE == 0);

  typedef struct packed {
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [15:0] duty;
    logic [15:0] period;
    logic [15:0] capt;
    logic [7:0] holdBuf;
    logic [7:0] rdata;
    logic dWr;
    logic dRd;
    logic [7:0] dAddr;
    logic [1:0] extSync;
    logic [1:0] capSync;
    logic capPrev;
    logic outPin;
    logic outPinN;
    logic capEv;
  } ptm_top_t;
  ptm_top_t st_reg;
  ptm_top_t st_next;
  ptm_cfg_if #(.W(W)) cfg ();
  logic [15:0] cnt16;
  logic [7:0] wByte;
  logic capIn;
  logic capRise;
  logic capFall;
  logic capTake;

  // Extends a narrow field to the 16-bit register image
  function automatic logic [15:0] widen(input logic [W-1:0] v);
    widen = 16'(v);
  endfunction

  // Keeps only the implemented bits of a pair
  function automatic logic [15:0] trim(input logic [15:0] v);
    trim = widen(v[W-1:0]);
  endfunction

  assign cnt16 = widen(cfg.count);
  assign wByte = hwdata[7:0];

  // ===========================================================================
  // Decoded controls to the core
  assign cfg.pauseEn = st_reg.ctrl0[ptm_pkg::PAUSE_BIT];
  assign cfg.clkSel = st_reg.ctrl0[ptm_pkg::CKSEL_LSB +: 3];
  assign cfg.runEn = st_reg.ctrl0[ptm_pkg::RUN_BIT];
  assign cfg.mode = st_reg.ctrl1[ptm_pkg::MODE_LSB +: 2];
  assign cfg.pinFunc = st_reg.ctrl1[ptm_pkg::PINF_LSB +: 2];
  assign cfg.initLevel = st_reg.ctrl1[ptm_pkg::OINIT_BIT];
  assign cfg.polarity = st_reg.ctrl1[ptm_pkg::POL_BIT];
  assign cfg.clearSel = st_reg.ctrl1[ptm_pkg::CCLR_BIT];
  assign cfg.period = st_reg.period[W-1:0];
  assign cfg.duty = st_reg.duty[W-1:0];

  ptm_counter #(.W(W)) u_core (
    .clock(clock),
    .rstn(rstn),
    .extPinSync(st_reg.extSync[1]),
    .subTick(subClockTick),
    .hTick(highClockTick),
    .cfg(cfg)
  );

  // ===========================================================================
  // Capture edge detection, only past the second synchroniser stage
  assign capIn = st_reg.ctrl1[ptm_pkg::CAPSRC_BIT] ? st_reg.extSync[1] :
    st_reg.capSync[1];
  assign capRise = capIn && !st_reg.capPrev;
  assign capFall = !capIn && st_reg.capPrev;
  always_comb
  begin
    unique case (cfg.pinFunc)
      2'b00: capTake = capRise;
      2'b01: capTake = capFall;
      2'b10: capTake = capRise || capFall;
      2'b11: capTake = 1'b0;
    endcase
  end

  // ===========================================================================
  // Next state: bus data phase, synchronisers, capture and pin drive
  always_comb
  begin
    st_next = st_reg;
    st_next.extSync = {st_reg.extSync[0], extClockPin};
    st_next.capSync = {st_reg.capSync[0], captureInputPin};
    st_next.capPrev = capIn;
    st_next.capEv = 1'b0;
    st_next.dWr = hsel && hready && htrans[1] && hwrite;
    st_next.dRd = hsel && hready && htrans[1] && !hwrite;
    st_next.dAddr = haddr[7:0];
    // Capture latches the counter into the duty pair, or into the extra pair
    if (cfg.mode == 2'b01 && cfg.runEn && capTake)
    begin
      st_next.capEv = 1'b1;
      if (HAS_CAP && st_reg.ctrl2[2:1] != 2'b00 && capRise)
        st_next.capt = cnt16;
      else
        st_next.duty = cnt16;
    end
    // Writes land in the data phase
    if (st_reg.dWr)
    begin
      unique case (st_reg.dAddr)
        ptm_pkg::CTRL0_OFS: st_next.ctrl0 = wByte & ptm_pkg::CTRL0_MASK;
        ptm_pkg::CTRL1_OFS: st_next.ctrl1 = wByte;
        ptm_pkg::CTRL2_OFS: if (HAS_CAP) st_next.ctrl2 = wByte & ptm_pkg::CTRL2_MASK;
        ptm_pkg::DUTYL_OFS, ptm_pkg::PERL_OFS: st_next.holdBuf = wByte;
        ptm_pkg::CAPL_OFS: if (HAS_CAP) st_next.holdBuf = wByte;
        ptm_pkg::DUTYH_OFS: st_next.duty = trim({wByte, st_reg.holdBuf});
        ptm_pkg::PERH_OFS: st_next.period = trim({wByte, st_reg.holdBuf});
        ptm_pkg::CAPH_OFS: if (HAS_CAP) st_next.capt = {wByte, st_reg.holdBuf};
        default: ; // Counter pair and unmapped addresses ignore writes
      endcase
    end
    // Read data formed in the address phase and registered for the data phase
    st_next.rdata = 8'h00;
    if (hsel && hready && htrans[1] && !hwrite)
    begin
      unique case (haddr[7:0])
        ptm_pkg::CTRL0_OFS: st_next.rdata = st_reg.ctrl0;
        ptm_pkg::CTRL1_OFS: st_next.rdata = st_reg.ctrl1;
        ptm_pkg::CTRL2_OFS: st_next.rdata = st_reg.ctrl2;
        ptm_pkg::CNTL_OFS, ptm_pkg::DUTYL_OFS, ptm_pkg::PERL_OFS:
          st_next.rdata = st_reg.holdBuf;
        ptm_pkg::CAPL_OFS: st_next.rdata = HAS_CAP ? st_reg.holdBuf : 8'h00;
        ptm_pkg::CNTH_OFS:
        begin
          st_next.rdata = cnt16[15:8];
          st_next.holdBuf = cnt16[7:0];
        end
        ptm_pkg::DUTYH_OFS:
        begin
          st_next.rdata = st_reg.duty[15:8];
          st_next.holdBuf = st_reg.duty[7:0];
        end
        ptm_pkg::PERH_OFS:
        begin
          st_next.rdata = st_reg.period[15:8];
          st_next.holdBuf = st_reg.period[7:0];
        end
        ptm_pkg::CAPH_OFS:
        begin
          if (HAS_CAP)
          begin
            st_next.rdata = st_reg.capt[15:8];
            st_next.holdBuf = st_reg.capt[7:0];
          end
        end
        default: st_next.rdata = 8'h00;
      endcase
    end
    // Output pin: held low in timer and capture modes, where the level is left undefined
    st_next.outPin = (cfg.mode == 2'b11 || cfg.mode == 2'b01) ? 1'b0 :
      cfg.outLevel ^ cfg.polarity;
    st_next.outPinN = !st_next.outPin;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      st_reg <= '0;
      st_reg.outPinN <= 1'b1; // Complement pin stays the inverse even in reset
    end
    else
      st_reg <= st_next;
  end

  // ===========================================================================
  // Outputs straight from flops; zero wait states, always OKAY
  assign hrdata = {24'h0000_00, st_reg.rdata};
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign timerOutputPin = st_reg.outPin;
  assign timerOutputInvertedPin = st_reg.outPinN;
  assign captureEvent = st_reg.capEv;

  // ===========================================================================
  // Checks
  ctrl0_low_a: assert property (@(posedge clock) disable iff (!rstn)
    st_reg.ctrl0[2:0] == 3'b000) else $error("control zero low bits set");
  hi_write_a: assert property (@(posedge clock) disable iff (!rstn)
    st_reg.dWr && st_reg.dAddr == ptm_pkg::PERH_OFS |=>
    st_reg.period == trim({$past(hwdata[7:0]), $past(st_reg.holdBuf)}))
    else $error("period pair write wrong");
  lo_write_a: assert property (@(posedge clock) disable iff (!rstn)
    st_reg.dWr && st_reg.dAddr == ptm_pkg::DUTYL_OFS |=> $stable(st_reg.duty))
    else $error("low write touched duty");
  hi_read_a: assert property (@(posedge clock) disable iff (!rstn)
    hsel && hready && htrans[1] && !hwrite && haddr[7:0] == ptm_pkg::PERH_OFS |=>
    st_reg.holdBuf == $past(st_reg.period[7:0])) else $error("buffer not loaded");
  lo_read_a: assert property (@(posedge clock) disable iff (!rstn)
    hsel && hready && htrans[1] && !hwrite && haddr[7:0] == ptm_pkg::CNTL_OFS |=>
    hrdata[7:0] == $past(st_reg.holdBuf)) else $error("low read not buffer");
  cnt_ro_a: assert property (@(posedge clock) disable iff (!rstn)
    st_reg.dWr && st_reg.dAddr == ptm_pkg::CNTH_OFS |=> $stable(st_reg.holdBuf))
    else $error("counter pair took a write");
  comp_pin_a: assert property (@(posedge clock) disable iff (!rstn)
    timerOutputInvertedPin == !timerOutputPin) else $error("pins not inverse");
  rd_cover_c: cover property (@(posedge clock) disable iff (!rstn)
    st_reg.dRd && st_reg.dAddr == ptm_pkg::CNTH_OFS);
  cap_cover_c: cover property (@(posedge clock) disable iff (!rstn) st_reg.capEv);
endmodule

// file: test/ptm_top_test.sv
// Self-checking bench for the periodic timer top, instance 0 (16-bit, with capture pair).
// Assumes zero-wait-state AHB-Lite slave; hready is fed back from hreadyout.
module ptm_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Signals
  logic clock, rstn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic extClockPin, captureInputPin, subClockTick, highClockTick;
  logic timerOutputPin, timerOutputInvertedPin, captureEvent;
  logic [15:0] p, q;
  logic [2:0] srcs [6] = '{3'b110, 3'b111, 3'b100, 3'b101, 3'b011, 3'b010};
  int mismatches, checks_done, seed, n, k, i, h;
  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;
  ptm_top #(.INSTANCE(0)) u_ptm_top (.clock(clock), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .extClockPin(extClockPin),
    .captureInputPin(captureInputPin), .subClockTick(subClockTick),
    .highClockTick(highClockTick), .timerOutputPin(timerOutputPin),
    .timerOutputInvertedPin(timerOutputInvertedPin), .captureEvent(captureEvent));
  // 20 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // ==========================================================================
  // Tasks and expectation functions
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ok(input logic c);
    check({31'h0000_0000, c}, 32'h0000_0001);
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge clock);
  endtask
  // Wait for ready; only the watchdog ends a real hang
  task automatic waitrdy;
    @(posedge clock);
    while (hready !== 1'b1)
      @(posedge clock);
  endtask
  // One single word transfer; read data lands in rd
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    htrans <= 2'b10;
    waitrdy;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    waitrdy;
    rd = hrdata;
  endtask
  // Pairs: low byte first on write, high byte first on read
  task automatic wpair(input logic [7:0] al, input logic [7:0] ah, input logic [15:0] d);
    xfer(1'b1, al, d[7:0]);
    xfer(1'b1, ah, d[15:8]);
  endtask
  task automatic rpair(input logic [7:0] ah, input logic [7:0] al, output logic [15:0] d);
    xfer(1'b0, ah, 8'h00);
    d[15:8] = rd[7:0];
    xfer(1'b0, al, 8'h00);
    d[7:0] = rd[7:0];
  endtask
  task automatic rcnt(output logic [15:0] d);
    rpair(ptm_pkg::CNTH_OFS, ptm_pkg::CNTL_OFS, d);
  endtask
  // One clock event of the chosen source: pin edge pair, sub tick or high tick
  task automatic pulse(input logic [2:0] cs);
    if (cs[2:1] == 2'b11)
    begin
      extClockPin <= 1'b1;
      cyc(3);
      extClockPin <= 1'b0;
      cyc(3);
    end
    else if (cs[2])
    begin
      subClockTick <= 1'b1;
      cyc(1);
      subClockTick <= 1'b0;
      cyc(1);
    end
    else
    begin
      highClockTick <= 1'b1;
      cyc(1);
      highClockTick <= 1'b0;
      cyc(1);
    end
  endtask
  // Pin level after one duty match in compare mode
  function automatic logic cmpLevel(input logic [1:0] pf, input logic oc);
    case (pf)
      2'b00: cmpLevel = oc;
      2'b01: cmpLevel = 1'b0;
      2'b10: cmpLevel = 1'b1;
      default: cmpLevel = ~oc;
    endcase
  endfunction
  task automatic end_sim;
    $display("checks_done %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Watchdog, well beyond the expected run length
  initial
  begin
    repeat (40000) @(posedge clock);
    mismatches++;
    end_sim;
  end
  // ==========================================================================
  // Main sequence
  initial
  begin
    {hsel, hwrite, extClockPin, captureInputPin, subClockTick, highClockTick} = 6'h00;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    htrans = 2'b00;
    hsize = 3'b010;
    rstn = 1'b0;
    seed = 81268;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    // Reset values, plus the unmapped word after the map
    for (i = 0; i < 12; i++)
    begin
      xfer(1'b0, 8'(i * 4), 8'h00);
      check(rd, 32'h0000_0000);
    end
    check({31'h0000_0000, hresp}, 32'h0000_0000);
    xfer(1'b1, ptm_pkg::CTRL0_OFS, 8'hF7);
    check(rd, 32'h0000_0000);
    xfer(1'b0, ptm_pkg::CTRL0_OFS, 8'h00);
    check(rd, 32'h0000_00F0);
    xfer(1'b1, ptm_pkg::CTRL0_OFS, 8'h00);
    xfer(1'b1, ptm_pkg::CTRL2_OFS, 8'hFF);
    xfer(1'b0, ptm_pkg::CTRL2_OFS, 8'h00);
    check(rd, 32'h0000_0007);
    // Random values through every writable pair
    for (i = 0; i < 4; i++)
    begin
      v = $random(seed);
      wpair(ptm_pkg::DUTYL_OFS, ptm_pkg::DUTYH_OFS, v[15:0]);
      wpair(ptm_pkg::PERL_OFS, ptm_pkg::PERH_OFS, v[31:16]);
      wpair(ptm_pkg::CAPL_OFS, ptm_pkg::CAPH_OFS, ~v[15:0]);
      rpair(ptm_pkg::DUTYH_OFS, ptm_pkg::DUTYL_OFS, p);
      check({16'h0000, p}, {16'h0000, v[15:0]});
      rpair(ptm_pkg::PERH_OFS, ptm_pkg::PERL_OFS, p);
      check({16'h0000, p}, {16'h0000, v[31:16]});
      rpair(ptm_pkg::CAPH_OFS, ptm_pkg::CAPL_OFS, p);
      check({16'h0000, p}, {16'h0000, ~v[15:0]});
    end
    // The holding buffer is shared between pairs, and low reads return it
    xfer(1'b1, ptm_pkg::DUTYL_OFS, 8'hA5);
    xfer(1'b1, ptm_pkg::PERH_OFS, 8'h00);
    rpair(ptm_pkg::PERH_OFS, ptm_pkg::PERL_OFS, p);
    check({16'h0000, p}, 32'h0000_00A5);
    xfer(1'b0, ptm_pkg::CAPL_OFS, 8'h00);
    check(rd, 32'h0000_00A5);
    wpair(ptm_pkg::CNTL_OFS, ptm_pkg::CNTH_OFS, 16'h5A5A);
    rcnt(p);
    check({16'h0000, p}, 32'h0000_0000);
    // Each pin and sub source counts exactly its own events, each high source one per 16 or 64 high ticks; period zero, timer mode
    wpair(ptm_pkg::PERL_OFS, ptm_pkg::PERH_OFS, 16'h0000);
    xfer(1'b1, ptm_pkg::CTRL1_OFS, 8'hC0);
    foreach (srcs[j])
    begin
      n = 2 + ($random(seed) & 7);
      k = n * ((srcs[j] == 3'b011) ? 64 : (srcs[j] == 3'b010) ? 16 : 1);
      xfer(1'b1, ptm_pkg::CTRL0_OFS, {1'b0, srcs[j], 4'h8});
      cyc(3);
      repeat (k) pulse(srcs[j]);
      cyc(4);
      xfer(1'b1, ptm_pkg::CTRL0_OFS, {1'b0, srcs[j], 4'h0});
      rcnt(p);
      check({16'h0000, p}, 32'(n));
    end
    // System clock: stop holds, pause holds and resumes, run rise clears
    xfer(1'b1, ptm_pkg::CTRL0_OFS, 8'h18);
    cyc(20);
    xfer(1'b1, ptm_pkg::CTRL0_OFS, 8'h98);
    rcnt(p);
    cyc(10);
    rcnt(q);
    check({16'h0000, q}, {16'h0000, p});
    ok(p >= 16'h0014);
    xfer(1'b1, ptm_pkg::CTRL0_OFS, 8'h18);
    cyc(5);
    xfer(1'b1, ptm_pkg::CTRL0_OFS, 8'h10);
    rcnt(q);
    ok(q > p + 16'h0004 && q < p + 16'h0010);
    cyc(10);
    rcnt(p);
    check({16'h0000, p}, {16'h0000, q});
    xfer(1'b1, ptm_pkg::CTRL0_OFS, 8'h18);
    xfer(1'b1, ptm_pkg::CTRL0_OFS, 8'h10);
    rcnt(p);
    ok(p < 16'h0005);
    xfer(1'b1, ptm_pkg::CTRL0_OFS, 8'h08);
    cyc(40);
    xfer(1'b1, ptm_pkg::CTRL0_OFS, 8'h00);
    rcnt(p);
    ok(p >= 16'h0009 && p <= 16'h000D);
    // Clear on period match, then on duty match; stopped before each change
    wpair(ptm_pkg::PERL_OFS, ptm_pkg::PERH_OFS, 16'h0005);
    wpair(ptm_pkg::DUTYL_OFS, ptm_pkg::DUTYH_OFS, 16'h0003);
    for (n = 0; n < 2; n++)
    begin
      xfer(1'b1, ptm_pkg::CTRL0_OFS, 8'h00);
      xfer(1'b1, ptm_pkg::CTRL1_OFS, {7'h60, n[0]});
      xfer(1'b1, ptm_pkg::CTRL0_OFS, 8'h18);
      h = 0;
      for (k = 0; k < 12; k++)
      begin
        cyc(k + 1);
        xfer(1'b1, ptm_pkg::CTRL0_OFS, 8'h98);
        rcnt(p);
        h = (p > h) ? p : h;
        xfer(1'b1, ptm_pkg::CTRL0_OFS, 8'h18);
      end
      check(32'(h), n ? 32'h0000_0003 : 32'h0000_0005);
    end
    // Compare output: every pin function, initial level and polarity
    wpair(ptm_pkg::PERL_OFS, ptm_pkg::PERH_OFS, 16'h0009);
    for (i = 0; i < 16; i++)
    begin
      xfer(1'b1, ptm_pkg::CTRL0_OFS, 8'h00);
      xfer(1'b1, ptm_pkg::CTRL1_OFS, {2'b00, i[1:0], i[2], i[3], 2'b00});
      xfer(1'b1, ptm_pkg::CTRL0_OFS, 8'h08);
      cyc(5);
      check({31'h0000_0000, timerOutputPin}, {31'h0000_0000, i[2] ^ i[3]});
      cyc(20);
      check({31'h0000_0000, timerOutputPin}, {31'h0, cmpLevel(i[1:0], i[2]) ^ i[3]});
      check({31'h0000_0000, timerOutputInvertedPin},
        {31'h0, ~(cmpLevel(i[1:0], i[2]) ^ i[3])});
    end
    // PWM forced levels, then a running waveform must show both levels
    for (i = 0; i < 8; i++)
    begin
      xfer(1'b1, ptm_pkg::CTRL0_OFS, 8'h00);
      xfer(1'b1, ptm_pkg::CTRL1_OFS, {3'b100, i[0], i[1], i[2], 2'b00});
      xfer(1'b1, ptm_pkg::CTRL0_OFS, 8'h18);
      cyc(8);
      check({31'h0000_0000, timerOutputPin}, {31'h0, (i[0] ? i[1] : ~i[1]) ^ i[2]});
    end
    xfer(1'b1, ptm_pkg::CTRL0_OFS, 8'h00);
    xfer(1'b1, ptm_pkg::CTRL1_OFS, 8'hA8);
    xfer(1'b1, ptm_pkg::CTRL0_OFS, 8'h18);
    h = 0;
    repeat (30)
    begin
      @(posedge clock);
      h += (timerOutputPin === 1'b1);
    end
    ok(h > 0 && h < 30);
    // Single pulse: active level after run rise, inactive for good after the duty match
    xfer(1'b1, ptm_pkg::CTRL0_OFS, 8'h00);
    xfer(1'b1, ptm_pkg::CTRL1_OFS, 8'hB8);
    xfer(1'b1, ptm_pkg::CTRL0_OFS, 8'h18);
    cyc(3);
    ok(timerOutputPin === 1'b1);
    cyc(30);
    ok(timerOutputPin === 1'b0);
    // Capture on a rising edge: pin chosen by the source bit, pair by control two
    for (i = 0; i < 2; i++)
    begin
      xfer(1'b1, ptm_pkg::CTRL0_OFS, 8'h00);
      xfer(1'b1, ptm_pkg::CTRL1_OFS, {6'h10, i[0], 1'b0});
      xfer(1'b1, ptm_pkg::CTRL2_OFS, i[0] ? 8'h00 : 8'h07);
      xfer(1'b1, ptm_pkg::CTRL0_OFS, 8'h18);
      n = 3 + ($random(seed) & 3);
      cyc(n);
      if (i[0])
        extClockPin <= 1'b1;
      else
        captureInputPin <= 1'b1;
      cyc(4);
      ok(captureEvent === 1'b1);
      cyc(1);
      ok(captureEvent === 1'b0);
      if (i[0])
        rpair(ptm_pkg::DUTYH_OFS, ptm_pkg::DUTYL_OFS, p);
      else
        rpair(ptm_pkg::CAPH_OFS, ptm_pkg::CAPL_OFS, p);
      check({16'h0000, p}, 32'(n + 1));
    end
    end_sim;
  end
endmodule
